// file: hw/dmem_pkg.sv
// Purpose: shared constants and types of the decoder
// Assumes: 50 MHz clk_sys, synchronous active-high reset
// Notes:   io addresses are in port-transfer numbering (0x00..0x3f)
package dmem_pkg;

  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int         CLK_MHZ         = 50;
  localparam int         PROG_ATOMIC_US  = 3400;
  localparam int         PROG_SPLIT_US   = 1800;
  localparam int         PROG_ATOMIC_CYC = PROG_ATOMIC_US * CLK_MHZ;
  localparam int         PROG_SPLIT_CYC  = PROG_SPLIT_US * CLK_MHZ;
  localparam logic [2:0] EE_RD_STALL     = 3'h4;
  localparam logic [2:0] EE_WR_STALL     = 3'h2;
  localparam logic [2:0] MWE_WINDOW      = 3'h4;

  // ------------------------------------------------------------------
  // data space map
  // ------------------------------------------------------------------
  localparam logic [15:0] IO_BASE   = 16'h0020;
  localparam logic [15:0] EXT_BASE  = 16'h0060;
  localparam logic [15:0] SRAM_BASE = 16'h0100;
  localparam logic [15:0] SRAM_END  = 16'h10ff;
  localparam logic [15:0] IO_DS_OFS = 16'h0020;
  localparam int          RF_WORDS  = 32;
  localparam int          SRAM_WORDS = 4096;
  localparam int          EE_WORDS  = 2048;
  localparam int          EE_AW     = 11;
  localparam logic [4:0]  PTR_X_LO  = 5'h1a;
  localparam logic [4:0]  PTR_Y_LO  = 5'h1c;
  localparam logic [4:0]  PTR_Z_LO  = 5'h1e;

  // ------------------------------------------------------------------
  // io registers
  // ------------------------------------------------------------------
  localparam logic [5:0] IO_FLAGS   = 6'h1c;
  localparam logic [5:0] IO_GP0     = 6'h1e;
  localparam logic [5:0] IO_EE_CTL  = 6'h1f;
  localparam logic [5:0] IO_EE_ADRH = 6'h22;
  localparam logic [5:0] IO_GP1     = 6'h2a;
  localparam logic [5:0] IO_GP2     = 6'h2b;
  localparam logic [7:0] REG_RST    = 8'h00;

  // eeprom control bit positions
  localparam int EEC_RD = 0;
  localparam int EEC_PE = 1;
  localparam int EEC_MPE = 2;
  localparam int EEC_PM = 4;
  localparam logic [1:0] PM_ATOMIC = 2'h0;
  localparam logic [1:0] PM_ERASE  = 2'h1;
  localparam logic [1:0] PM_WRITE  = 2'h2;
  localparam logic [7:0] EE_ERASED = 8'hff;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    K_LOAD = 3'b000, K_STORE = 3'b001, K_IN = 3'b010, K_OUT = 3'b011,
    K_BSET = 3'b100, K_BCLR = 3'b101, K_SKIP1 = 3'b110, K_SKIP0 = 3'b111
  } acc_kind_e;
  typedef enum logic [2:0] {
    M_DIRECT = 3'b000, M_IND = 3'b001, M_DISP = 3'b010,
    M_PREDEC = 3'b011, M_POSTINC = 3'b100
  } mode_e;
  typedef enum logic [1:0] {P_X = 2'b00, P_Y = 2'b01, P_Z = 2'b10} ptr_e;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_ACC = 2'b01, S_STALL = 2'b10
  } seq_e;
  typedef enum logic [2:0] {
    R_RF = 3'b000, R_IO = 3'b001, R_EXT = 3'b010, R_SRAM = 3'b011,
    R_NONE = 3'b100
  } region_e;
  typedef enum logic [2:0] {
    IS_NONE = 3'b000, IS_FLAGS = 3'b001, IS_GP0 = 3'b010,
    IS_GP1 = 3'b011, IS_GP2 = 3'b100, IS_EE = 3'b101
  } io_sel_e;
  typedef enum logic [1:0] {
    E_CTL = 2'b00, E_DATA = 2'b01, E_ADRL = 2'b10, E_ADRH = 2'b11
  } ee_reg_e;

endpackage : dmem_pkg

// file: hw/ee_link_if.sv
// Purpose: link between the decoder and the eeprom access unit
// Assumes: both ends on clk_sys
// Notes:   wr is a one-cycle write strobe with a bit mask
interface ee_link_if;
  import dmem_pkg::*;
  logic              wr;
  ee_reg_e           sel;
  logic [7:0]        wdata;
  logic [7:0]        mask;
  logic              rd_fire;
  logic              wr_fire;
  logic [7:0]        ctl_q;
  logic [7:0]        data_q;
  logic [EE_AW-1:0]  addr_q;
  modport host (output wr, sel, wdata, mask,
                input  rd_fire, wr_fire, ctl_q, data_q, addr_q);
  modport ee   (input  wr, sel, wdata, mask,
                output rd_fire, wr_fire, ctl_q, data_q, addr_q);
endinterface : ee_link_if

// file: hw/eeprom_ctrl.sv
// Purpose: eeprom address, data and control registers and the array
// Assumes: writes arrive as masked strobes from the decoder
// Notes:   programming time is counted on clk_sys
module eeprom_ctrl #(
  parameter int PROG_ATOMIC_CYC = dmem_pkg::PROG_ATOMIC_CYC,
  parameter int PROG_SPLIT_CYC  = dmem_pkg::PROG_SPLIT_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  ee_link_if.ee     lk
);
  import dmem_pkg::*;

  typedef struct packed {
    logic             mwe;
    logic [2:0]       mwe_cnt;
    logic             pe;
    logic [1:0]       pm;
    logic [1:0]       op;
    logic [17:0]      cnt;
    logic [7:0]       data;
    logic [EE_AW-1:0] addr;
    logic [EE_AW-1:0] paddr;
    logic [7:0]       pdata;
  } ee_s;

  ee_s        s_r;
  ee_s        s_nxt;
  logic [7:0] mem [0:EE_WORDS-1];
  logic [7:0] set_c;
  logic       done_c;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    set_c = lk.wdata & lk.mask;
    lk.rd_fire = 1'b0;
    lk.wr_fire = 1'b0;
    done_c = s_r.pe && (s_r.cnt == 18'h00001);
    if (s_r.mwe) begin
      s_nxt.mwe_cnt = s_r.mwe_cnt - 3'h1;
      if (s_r.mwe_cnt == 3'h1) begin
        s_nxt.mwe = 1'b0; // [RULE_21]
      end
    end
    if (s_r.pe) begin
      s_nxt.cnt = s_r.cnt - 18'h00001;
      if (done_c) begin
        s_nxt.pe = 1'b0; // [RULE_22] [RULE_14]
      end
    end
    if (lk.wr && lk.sel == E_CTL) begin
      if (!s_r.pe) begin
        s_nxt.pm = (s_r.pm & ~lk.mask[EEC_PM+:2]) | set_c[EEC_PM+:2];
      end
      // re-arming does not stretch the window
      if (set_c[EEC_MPE] && !s_r.mwe) begin
        s_nxt.mwe = 1'b1;
        s_nxt.mwe_cnt = MWE_WINDOW;
      end
      // reserved mode 2'b11 starts nothing
      if (set_c[EEC_PE] && s_r.mwe && !s_r.pe && s_r.pm != 2'h3) begin
        lk.wr_fire = 1'b1; // [RULE_15]
        s_nxt.pe = 1'b1;
        s_nxt.op = s_r.pm;
        s_nxt.paddr = s_r.addr;
        s_nxt.pdata = s_r.data;
        s_nxt.cnt = (s_r.pm == PM_ATOMIC) ? 18'(PROG_ATOMIC_CYC)
                                          : 18'(PROG_SPLIT_CYC);
      end
      if (set_c[EEC_RD] && !s_r.pe) begin
        lk.rd_fire = 1'b1;
        s_nxt.data = mem[s_r.addr]; // [RULE_23] [RULE_12]
      end
    end
    if (lk.wr && lk.sel == E_DATA) begin
      s_nxt.data = (s_r.data & ~lk.mask) | set_c;
    end
    // the address ignores writes while programming; reset still clears it
    if (lk.wr && !s_r.pe && lk.sel == E_ADRL) begin
      s_nxt.addr[7:0] = (s_r.addr[7:0] & ~lk.mask) | set_c;
    end
    if (lk.wr && !s_r.pe && lk.sel == E_ADRH) begin
      s_nxt.addr[EE_AW-1:8] = (s_r.addr[EE_AW-1:8] & ~lk.mask[2:0])
                              | set_c[2:0];
    end
    if (rst) begin
      s_nxt.mwe = 1'b0;
      s_nxt.mwe_cnt = 3'h0;
      s_nxt.data = REG_RST;
      s_nxt.addr = '0;
      // a running write goes on
      if (!s_r.pe) begin // [RULE_18]
        s_nxt.pe = 1'b0;
        s_nxt.pm = PM_ATOMIC;
        s_nxt.op = PM_ATOMIC;
        s_nxt.cnt = '0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    s_r <= s_nxt;
  end

  always_ff @(posedge clk_sys) begin
    if (done_c) begin
      case (s_r.op)
        PM_ERASE: mem[s_r.paddr] <= EE_ERASED;
        PM_WRITE: mem[s_r.paddr] <= mem[s_r.paddr] & s_r.pdata;
        default:  mem[s_r.paddr] <= s_r.pdata;
      endcase
    end
  end

  assign lk.ctl_q  = {2'b00, s_r.pm, 1'b0, s_r.mwe, s_r.pe, 1'b0};
  assign lk.data_q = s_r.data;
  assign lk.addr_q = s_r.addr;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  mwe_window_a: assert property ( // [RULE_21]
    $rose(s_r.mwe) |-> s_r.mwe [*4] ##1 !s_r.mwe)
    else $error("enable window not four cycles");
  pe_unlock_a: assert property ( // [RULE_15]
    $rose(s_r.pe) |-> $past(s_r.mwe))
    else $error("write started unlocked");
  pe_end_a: assert property ( // [RULE_22]
    s_r.pe && s_r.cnt == 18'h00001 |=> !s_r.pe)
    else $error("strobe not cleared at end");
  rst_keep_a: assert property ( // [RULE_18]
    disable iff (1'b0) rst && s_r.pe && s_r.cnt > 18'h00001 |=> s_r.pe)
    else $error("reset aborted an eeprom write");

endmodule : eeprom_ctrl

// file: hw/data_memory_space_decoder.sv
// Purpose: data address decoder and access sequencer for load/store/io
// Assumes: cpu holds a request until req_ready; one request at a time
// Notes:   register file and sram live here as plain arrays
//
// Contract
// [RULE_01] map 32 regs, 64 io, 160 ext, 4096 sram
// [RULE_02] extended io only by load/store
// [RULE_03] port io 0x00-0x3f, data address plus 0x20
// [RULE_04] bit set/clear/skip on io 0x00-0x1f
// [RULE_05] bit ops touch only the addressed bit
// [RULE_06] some status flags clear on writing one
// [RULE_07] sram access takes two cycles
// [RULE_08] direct addressing reaches the whole space
// [RULE_09] displacement up to 63 beyond y or z
// [RULE_10] r26 to r31 form the pointer pairs
// [RULE_11] pre-decrement and post-increment update the pointer
// [RULE_12] eeprom is separate 2k byte space
// [RULE_13] eeprom registers sit in io space
// [RULE_14] self-timed write completion visible to software
// [RULE_15] eeprom write needs unlock sequence first
// [RULE_16] eeprom read stalls cpu four cycles
// [RULE_17] eeprom write stalls cpu two cycles
// [RULE_18] reset does not abort running eeprom write
// [RULE_19] three general purpose io storage registers
// [RULE_20] software writes zero to reserved bits
// [RULE_21] master write enable self-clears after four cycles
// [RULE_22] programming strobe clears when write ends
// [RULE_23] read data ready within triggering instruction
// [RULE_24] unmapped io writes ignored, reads zero
module data_memory_space_decoder #(
  parameter int PROG_ATOMIC_CYC = dmem_pkg::PROG_ATOMIC_CYC,
  parameter int PROG_SPLIT_CYC  = dmem_pkg::PROG_SPLIT_CYC
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                req_valid,
  input  wire dmem_pkg::acc_kind_e req_kind,
  input  wire dmem_pkg::mode_e     req_mode,
  input  wire dmem_pkg::ptr_e      req_ptr,
  input  wire logic [15:0]         req_addr,
  input  wire logic [5:0]          req_disp,
  input  wire logic [7:0]          req_wdata,
  input  wire logic [2:0]          req_bit,
  input  wire logic [7:0]          flag_event,
  output logic                     req_ready,
  output logic                     rsp_done,
  output logic [7:0]               rsp_rdata,
  output logic                     rsp_skip
);
  import dmem_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    seq_e        state;
    logic        ready;
    logic        done;
    logic        skip;
    logic [7:0]  rdata;
    logic [15:0] addr;
    acc_kind_e   kind;
    logic [7:0]  wdata;
    logic [7:0]  mask;
    logic [2:0]  bitn;
    logic        ptr_we;
    logic [4:0]  ptr_idx;
    logic [15:0] ptr_val;
    logic [2:0]  cnt;
    logic [7:0]  flags;
    logic [7:0]  gp0;
    logic [7:0]  gp1;
    logic [7:0]  gp2;
  } top_s;

  top_s        st_r;
  top_s        st_nxt;
  logic [7:0]  rf   [0:RF_WORDS-1];
  logic [7:0]  sram [0:SRAM_WORDS-1];

  logic        take_c;
  logic [4:0]  pidx_c;
  logic [15:0] pval_c;
  logic [15:0] ea_c;
  logic [15:0] io_off_c;
  logic [15:0] sram_off_c;
  region_e     reg_c;
  io_sel_e     io_c;
  logic        is_wr_c;
  logic        is_rd_c;
  logic [7:0]  rd_val_c;
  logic [7:0]  clr_c;
  logic        rf_we_c;
  logic        sram_we_c;
  logic        gp0_bit_c;
  logic        zero_rd_c;

  ee_link_if lk ();

  // ------------------------------------------------------------------
  // decode functions
  // ------------------------------------------------------------------
  function automatic region_e region(input logic [15:0] a);
    if (a < IO_BASE) begin
      return R_RF; // [RULE_01]
    end else if (a < EXT_BASE) begin
      return R_IO;
    end else if (a < SRAM_BASE) begin
      return R_EXT;
    end else if (a <= SRAM_END) begin
      return R_SRAM;
    end
    return R_NONE;
  endfunction : region

  function automatic io_sel_e io_decode(input logic [5:0] a);
    if (a == IO_FLAGS) begin
      return IS_FLAGS;
    end else if (a == IO_GP0) begin
      return IS_GP0; // [RULE_19]
    end else if (a == IO_GP1) begin
      return IS_GP1;
    end else if (a == IO_GP2) begin
      return IS_GP2;
    end else if (a >= IO_EE_CTL && a <= IO_EE_ADRH) begin
      return IS_EE; // [RULE_13]
    end
    return IS_NONE;
  endfunction : io_decode

  function automatic logic [4:0] ptr_base(input ptr_e p);
    case (p)
      P_Y:     return PTR_Y_LO;
      P_Z:     return PTR_Z_LO;
      default: return PTR_X_LO; // [RULE_10]
    endcase
  endfunction : ptr_base

  // ------------------------------------------------------------------
  // address computation
  // ------------------------------------------------------------------
  always_comb begin
    take_c = req_valid && st_r.ready;
    pidx_c = ptr_base(req_ptr);
    pval_c = {rf[pidx_c + 5'h01], rf[pidx_c]};
    case (req_kind)
      // a 6-bit io number cannot reach 0x60 and up
      K_IN, K_OUT:
        ea_c = {10'h000, req_addr[5:0]} + IO_DS_OFS; // [RULE_02] [RULE_03]
      K_BSET, K_BCLR, K_SKIP1, K_SKIP0:
        ea_c = {11'h000, req_addr[4:0]} + IO_DS_OFS; // [RULE_04]
      default: begin
        case (req_mode)
          M_IND, M_POSTINC: ea_c = pval_c;
          M_DISP:   ea_c = pval_c + {10'h000, req_disp}; // [RULE_09]
          M_PREDEC: ea_c = pval_c - 16'h0001;
          default:  ea_c = req_addr; // [RULE_08]
        endcase
      end
    endcase
  end

  // ------------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------------
  always_comb begin
    reg_c = region(st_r.addr);
    io_off_c = st_r.addr - IO_DS_OFS;
    sram_off_c = st_r.addr - SRAM_BASE;
    io_c = (reg_c == R_IO) ? io_decode(io_off_c[5:0]) : IS_NONE;
    is_wr_c = st_r.kind inside {K_STORE, K_OUT, K_BSET, K_BCLR};
    is_rd_c = !is_wr_c;
    case (io_c)
      IS_FLAGS: rd_val_c = st_r.flags;
      IS_GP0:   rd_val_c = st_r.gp0;
      IS_GP1:   rd_val_c = st_r.gp1;
      IS_GP2:   rd_val_c = st_r.gp2;
      IS_EE: begin
        case (ee_reg_e'(io_off_c[5:0] - IO_EE_CTL))
          E_CTL:   rd_val_c = lk.ctl_q;
          E_DATA:  rd_val_c = lk.data_q;
          E_ADRL:  rd_val_c = lk.addr_q[7:0];
          default: rd_val_c = {5'h00, lk.addr_q[EE_AW-1:8]};
        endcase
      end
      default: rd_val_c = 8'h00; // [RULE_24]
    endcase
    if (reg_c == R_RF) begin
      rd_val_c = rf[st_r.addr[4:0]];
    end else if (reg_c == R_SRAM) begin
      rd_val_c = sram[sram_off_c[11:0]];
    end
    zero_rd_c = reg_c inside {R_EXT, R_NONE}
             || (reg_c == R_IO && io_c == IS_NONE);
    rf_we_c = st_r.state == S_ACC && is_wr_c && reg_c == R_RF;
    sram_we_c = st_r.state == S_ACC && is_wr_c && reg_c == R_SRAM; // [RULE_07]
    gp0_bit_c = st_r.state == S_ACC && io_c == IS_GP0
             && st_r.kind inside {K_BSET, K_BCLR};
    clr_c = (st_r.state == S_ACC && is_wr_c && io_c == IS_FLAGS)
          ? (st_r.wdata & st_r.mask & ~flag_event) : 8'h00;
    lk.wr = st_r.state == S_ACC && is_wr_c && io_c == IS_EE;
    lk.sel = ee_reg_e'(io_off_c[5:0] - IO_EE_CTL);
    lk.wdata = st_r.wdata;
    lk.mask = st_r.mask;
  end

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    // an event beats a clearing write in one cycle
    st_nxt.flags = (st_r.flags & ~clr_c) | flag_event; // [RULE_06]
    case (st_r.state)
      S_IDLE: begin
        if (take_c) begin
          st_nxt.state = S_ACC;
          st_nxt.ready = 1'b0;
          st_nxt.addr = ea_c;
          st_nxt.kind = req_kind;
          st_nxt.bitn = req_bit;
          st_nxt.ptr_idx = pidx_c;
          st_nxt.ptr_we = req_kind inside {K_LOAD, K_STORE}
                       && req_mode inside {M_PREDEC, M_POSTINC};
          st_nxt.ptr_val = (req_mode == M_PREDEC) ? ea_c
                         : pval_c + 16'h0001; // [RULE_11]
          case (req_kind)
            K_BSET, K_BCLR: begin
              // a single-bit mask keeps neighbours and flags intact
              st_nxt.mask = 8'h01 << req_bit; // [RULE_05]
              st_nxt.wdata = (req_kind == K_BSET) ? 8'hff : 8'h00;
            end
            default: begin
              st_nxt.mask = 8'hff;
              st_nxt.wdata = req_wdata;
            end
          endcase
        end
      end
      S_ACC: begin
        st_nxt.rdata = is_rd_c ? rd_val_c : 8'h00;
        st_nxt.skip = (st_r.kind inside {K_SKIP1, K_SKIP0}) // [RULE_04]
                   && (rd_val_c[st_r.bitn] == (st_r.kind == K_SKIP1));
        if (is_wr_c) begin
          case (io_c)
            IS_GP0: st_nxt.gp0 = (st_r.gp0 & ~st_r.mask)
                               | (st_r.wdata & st_r.mask); // [RULE_05]
            IS_GP1: st_nxt.gp1 = st_r.wdata;
            IS_GP2: st_nxt.gp2 = st_r.wdata;
            default: ;
          endcase
        end
        if (lk.rd_fire) begin
          st_nxt.state = S_STALL;
          st_nxt.cnt = EE_RD_STALL; // [RULE_16]
        end else if (lk.wr_fire) begin
          st_nxt.state = S_STALL;
          st_nxt.cnt = EE_WR_STALL; // [RULE_17]
        end else begin
          st_nxt.state = S_IDLE;
          st_nxt.ready = 1'b1;
          st_nxt.done = 1'b1;
        end
      end
      S_STALL: begin
        st_nxt.cnt = st_r.cnt - 3'h1;
        if (st_r.cnt == 3'h1) begin
          st_nxt.state = S_IDLE;
          st_nxt.ready = 1'b1;
          st_nxt.done = 1'b1;
        end
      end
      default: st_nxt.state = S_IDLE;
    endcase
    if (rst) begin
      st_nxt = '0;
      st_nxt.state = S_IDLE;
      st_nxt.ready = 1'b1;
      st_nxt.flags = REG_RST;
      st_nxt.gp0 = REG_RST;
      st_nxt.gp1 = REG_RST;
      st_nxt.gp2 = REG_RST;
    end
  end

  always_ff @(posedge clk_sys) begin
    st_r <= st_nxt;
  end

  // arrays are not reset; pointer update lands on the same edge as the data write and wins over it
  always_ff @(posedge clk_sys) begin
    if (rf_we_c) begin
      rf[st_r.addr[4:0]] <= st_r.wdata;
    end
    if (st_r.state == S_ACC && st_r.ptr_we) begin
      rf[st_r.ptr_idx] <= st_r.ptr_val[7:0]; // [RULE_11]
      rf[st_r.ptr_idx + 5'h01] <= st_r.ptr_val[15:8];
    end
    if (sram_we_c) begin
      sram[sram_off_c[11:0]] <= st_r.wdata;
    end
  end

  eeprom_ctrl #(
    .PROG_ATOMIC_CYC (PROG_ATOMIC_CYC),
    .PROG_SPLIT_CYC  (PROG_SPLIT_CYC)
  ) u_ee (
    .clk_sys (clk_sys),
    .rst     (rst),
    .lk      (lk)
  );

  assign req_ready = st_r.ready;
  assign rsp_done  = st_r.done;
  assign rsp_rdata = st_r.rdata;
  assign rsp_skip  = st_r.skip;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence rd_wait_s;
    !st_r.done [*4] ##1 st_r.done;
  endsequence
  sequence wr_wait_s;
    !st_r.done [*2] ##1 st_r.done;
  endsequence

  sram_two_cyc_a: assert property ( // [RULE_07]
    take_c && region(ea_c) == R_SRAM
      |=> st_r.state == S_ACC ##1 st_r.done)
    else $error("sram access not two cycles");
  ee_rd_stall_a: assert property ( // [RULE_16]
    st_r.state == S_ACC && lk.rd_fire |=> rd_wait_s)
    else $error("read stall not four cycles");
  ee_wr_stall_a: assert property ( // [RULE_17]
    st_r.state == S_ACC && lk.wr_fire |=> wr_wait_s)
    else $error("write stall not two cycles");
  flag_clear_a: assert property ( // [RULE_06]
    1'b1 |=> (st_r.flags & $past(clr_c)) == 8'h00)
    else $error("written-one flag not cleared");
  flag_set_a: assert property ( // [RULE_06]
    1'b1 |=> (st_r.flags & $past(flag_event)) == $past(flag_event))
    else $error("flag event lost");
  bit_only_a: assert property ( // [RULE_05]
    gp0_bit_c
      |=> ((st_r.gp0 ^ $past(st_r.gp0)) & ~$past(st_r.mask)) == 8'h00)
    else $error("bit op changed another bit");
  unmapped_zero_a: assert property ( // [RULE_24]
    st_r.state == S_ACC && is_rd_c && zero_rd_c |=> st_r.rdata == 8'h00)
    else $error("unmapped read returned nonzero");
  ptr_upd_a: assert property ( // [RULE_11]
    take_c && req_kind inside {K_LOAD, K_STORE} && req_mode == M_POSTINC
      |=> ##1 {rf[$past(pidx_c, 2) + 5'h01], rf[$past(pidx_c, 2)]}
              == $past(pval_c, 2) + 16'h0001)
    else $error("pointer not updated");

endmodule : data_memory_space_decoder

// file: dv/cpu_model.sv
// Purpose: cpu load/store unit model
// Assumes: access starts just after an edge
// Notes:   released address and write-data lines show the inverse
module cpu_model (
  input  wire logic           clk_sys,
  input  wire logic           req_ready,
  input  wire logic           rsp_done,
  output logic                req_valid,
  output dmem_pkg::acc_kind_e req_kind,
  output dmem_pkg::mode_e     req_mode,
  output dmem_pkg::ptr_e      req_ptr,
  output logic [15:0]         req_addr,
  output logic [5:0]          req_disp,
  output logic [7:0]          req_wdata,
  output logic [2:0]          req_bit
);
  import dmem_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  initial req_valid = 1'b0;
  task automatic access(acc_kind_e k, mode_e m, ptr_e p, logic [15:0] a,
                        logic [5:0] d, logic [7:0] w, logic [2:0] b,
                        output int n);
    logic r;
    req_valid <= 1'b1;
    req_kind  <= k;
    req_mode  <= m;
    req_ptr   <= p;
    req_addr  <= a;
    req_disp  <= d;
    req_wdata <= w;
    req_bit   <= b;
    do begin
      r = req_ready;
      @(posedge clk_sys);
      #1;
    end while (!r);
    req_valid <= 1'b0;
    req_addr  <= ~a;
    req_wdata <= ~w;
    n = 1;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (!rsp_done && n < 20);
  endtask : access
endmodule : cpu_model

// file: dv/tb.sv
// Purpose: self-checking bench of the decoder
// Assumes: programming counts of 20 and 10 cycles
// Notes:   each scenario judges its own results
module tb;
  import dmem_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, req_valid, req_ready, rsp_done, rsp_skip;
  logic [7:0]  flag_event, req_wdata, rsp_rdata;
  logic [15:0] req_addr;
  logic [5:0]  req_disp;
  logic [2:0]  req_bit;
  acc_kind_e   req_kind;
  mode_e       req_mode;
  ptr_e        req_ptr;
  int          failures, n_compared, ncyc;
  data_memory_space_decoder #(.PROG_ATOMIC_CYC(20), .PROG_SPLIT_CYC(10))
    dut_u (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
    .req_kind(req_kind), .req_mode(req_mode), .req_ptr(req_ptr),
    .req_addr(req_addr), .req_disp(req_disp), .req_wdata(req_wdata),
    .req_bit(req_bit), .flag_event(flag_event), .req_ready(req_ready),
    .rsp_done(rsp_done), .rsp_rdata(rsp_rdata), .rsp_skip(rsp_skip));
  cpu_model cpu_u (.clk_sys(clk_sys), .req_ready(req_ready),
    .rsp_done(rsp_done), .req_valid(req_valid), .req_kind(req_kind),
    .req_mode(req_mode), .req_ptr(req_ptr), .req_addr(req_addr),
    .req_disp(req_disp), .req_wdata(req_wdata), .req_bit(req_bit));
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic op(acc_kind_e k, logic [15:0] a, logic [7:0] w = 8'h00,
                    logic [2:0] b = 3'h0, mode_e m = M_DIRECT,
                    ptr_e p = P_X, logic [5:0] d = 6'h00);
    cpu_u.access(k, m, p, a, d, w, b, ncyc);
  endtask : op
  task automatic ctl(logic [2:0] b);
    op(K_BSET, 16'h001f, 8'h00, b);
  endtask : ctl
  task automatic ee_wait;
    for (int i = 0; i < 40; i++) begin
      op(K_IN, 16'h001f);
      if (rsp_rdata[1] === 1'b0) break;
    end
    check("prog strobe", rsp_rdata & 8'h02, 16'h0000);
  endtask : ee_wait
  task automatic report_and_stop;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_map;
    op(K_STORE, 16'h0005, 8'h11);
    op(K_LOAD, 16'h0005);
    check("regfile", rsp_rdata, 16'h0011);
    op(K_STORE, 16'h004a, 8'h3c);
    op(K_IN, 16'h002a);
    check("gp1", rsp_rdata, 16'h003c);
    op(K_OUT, 16'h002b, 8'hc3);
    op(K_LOAD, 16'h004b);
    check("gp2", rsp_rdata, 16'h00c3);
    op(K_STORE, 16'h10ff, 8'h5a);
    check("sram cycles", 16'(ncyc), 16'h0002);
    op(K_LOAD, 16'h10ff);
    check("sram top", rsp_rdata, 16'h005a);
    op(K_STORE, 16'h0060, 8'h77);
    op(K_LOAD, 16'h0060);
    check("ext io", rsp_rdata, 16'h0000);
    op(K_OUT, 16'h0010, 8'hff);
    op(K_IN, 16'h0010);
    check("unmapped io", rsp_rdata, 16'h0000);
    op(K_STORE, 16'h1100, 8'h66);
    op(K_LOAD, 16'h1100);
    check("beyond sram", rsp_rdata, 16'h0000);
  endtask : t_map
  task automatic t_ptr;
    op(K_STORE, 16'h001e, 8'h00);
    op(K_STORE, 16'h001f, 8'h01);
    op(K_STORE, 16'h0000, 8'h99, 3'h0, M_DISP, P_Z, 6'h3f);
    op(K_LOAD, 16'h013f);
    check("disp store", rsp_rdata, 16'h0099);
    op(K_STORE, 16'h0000, 8'h42, 3'h0, M_POSTINC, P_Z);
    op(K_LOAD, 16'h001e);
    check("z after inc", rsp_rdata, 16'h0001);
    op(K_LOAD, 16'h0000, 8'h00, 3'h0, M_PREDEC, P_Z);
    check("predec load", rsp_rdata, 16'h0042);
  endtask : t_ptr
  task automatic t_bits;
    flag_event <= 8'h28;
    @(posedge clk_sys);
    #1;
    flag_event <= 8'h00;
    op(K_BSET, 16'h001c, 8'h00, 3'h5);
    op(K_IN, 16'h001c);
    check("flags", rsp_rdata, 16'h0008);
    op(K_OUT, 16'h001c, 8'h08);
    op(K_IN, 16'h001c);
    check("flags w1c", rsp_rdata, 16'h0000);
    op(K_OUT, 16'h001e, 8'h80);
    op(K_BSET, 16'h001e, 8'h00, 3'h0);
    op(K_SKIP1, 16'h001e, 8'h00, 3'h0);
    check("skip one", rsp_skip, 16'h0001);
    op(K_SKIP0, 16'h001e, 8'h00, 3'h0);
    check("no skip", rsp_skip, 16'h0000);
    op(K_BCLR, 16'h001e, 8'h00, 3'h7);
    op(K_SKIP0, 16'h001e, 8'h00, 3'h7);
    check("skip zero", rsp_skip, 16'h0001);
    op(K_IN, 16'h001e);
    check("gp0", rsp_rdata, 16'h0001);
  endtask : t_bits
  task automatic t_ee;
    op(K_OUT, 16'h0021, 8'h05);
    op(K_OUT, 16'h0022, 8'h07);
    op(K_OUT, 16'h0020, 8'h5a);
    ctl(3'h1);
    check("locked cycles", 16'(ncyc), 16'h0002);
    ctl(3'h2);
    op(K_LOAD, 16'h0000);
    op(K_LOAD, 16'h0000);
    ctl(3'h1);
    op(K_IN, 16'h001f);
    check("late strobe", rsp_rdata & 8'h06, 16'h0000);
    ctl(3'h2);
    ctl(3'h1);
    check("write stall", 16'(ncyc), 16'h0004);
    op(K_IN, 16'h001f);
    check("busy", rsp_rdata & 8'h02, 16'h0002);
    ee_wait;
    op(K_OUT, 16'h0020, 8'h00);
    ctl(3'h0);
    check("read stall", 16'(ncyc), 16'h0006);
    op(K_IN, 16'h0020);
    check("ee byte", rsp_rdata, 16'h005a);
    op(K_OUT, 16'h0020, 8'h33);
    ctl(3'h2);
    ctl(3'h1);
    rst <= 1'b1;
    @(posedge clk_sys);
    #1;
    rst <= 1'b0;
    op(K_IN, 16'h001f);
    check("busy after rst", rsp_rdata & 8'h02, 16'h0002);
    ee_wait;
    op(K_OUT, 16'h0021, 8'h05);
    op(K_OUT, 16'h0022, 8'h07);
    ctl(3'h0);
    op(K_IN, 16'h0020);
    check("ee after rst", rsp_rdata, 16'h0033);
  endtask : t_ee
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    // about 160 cycles of traffic
    #100000;
    failures++;
    report_and_stop;
  end
  initial begin
    rst = 1'b1;
    flag_event = 8'h00;
    repeat (5) @(posedge clk_sys);
    #1;
    rst <= 1'b0;
    t_map;
    t_ptr;
    t_bits;
    t_ee;
    report_and_stop;
  end
endmodule : tb
